// ### rtl/event_flag_latch.sv
// One bank of sticky event flags with write-zero-to-clear.
// Assumes set and write strobes come from logic on the same clock.
`default_nettype none
module event_flag_latch #(
    parameter int WIDTH = 6
) (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] setEvent,   // One-cycle event pulses.
    input  wire logic             writeStrobe, // Software write to the flag register.
    input  wire logic [WIDTH-1:0] writeData,  // Zero bits clear, one bits leave alone.
    output logic      [WIDTH-1:0] flags       // Latched flags.
);
    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    // A set in the same cycle as a clear wins, so no event is lost to a clearing write.
    always_comb
    begin
        flags_d = flags_q;
        if (writeStrobe)
        begin
            flags_d = flags_q & writeData;
        end
        flags_d = flags_d | setEvent;
    end

    // Registers only; frozen while the clock enable is low.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flags_q <= '0;
        end
        else if (ce)
        begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;
endmodule // event_flag_latch
`default_nettype wire

// ### rtl/power_supply_event_interrupts.sv
// Supply-monitor event flags, enables and shared interrupt toward the core.
// Assumes analog comparators and ADCs outside; source and comparator levels are asynchronous.
`default_nettype none
module power_supply_event_interrupts
    import psm_pkg::*;
#(
    parameter int MEAS_CYCLES = psm_pkg::MEAS_INTERVAL_CYC, // Background measurement period.
    parameter int DC_UNIT_CYCLES = psm_pkg::DC_TIMEOUT_CYC  // Smallest low-input timeout.
) (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic [7:0] sfrAddr,        // Register address.
    input  wire logic       sfrWr,          // Write strobe, one cycle.
    input  wire logic [7:0] sfrWrData,      // Write data.
    output logic      [7:0] sfrRdData,      // Read data for the current address.
    input  wire logic       mainSupplyPin,  // High while the switched supply is on main.
    input  wire logic       dcInputLowPin,  // Comparator: input below 1.2 V.
    input  wire logic       sagDetected,    // Pulse from the sag detector.
    input  wire logic       vswResultReady, // Pulse: switched-supply result valid.
    input  wire logic [7:0] vswResult,      // Switched-supply result.
    input  wire logic       batResultReady, // Pulse: battery result valid.
    input  wire logic [7:0] batResult,      // Battery result.
    output logic            adcStartPulse,  // Starts a switched-supply conversion.
    output logic            dcSwitchoverReq, // Asks the switch to move to battery.
    output logic            supplyIrq       // Shared supply-monitor interrupt.
);
    import psm_pkg::*;

    // Refuse parameters the counters cannot hold.
    if (MEAS_CYCLES < 2 || MEAS_CYCLES > (1 << 20) || DC_UNIT_CYCLES < 1 || DC_UNIT_CYCLES > (1 << 16))
    begin : gen_bad_param
        $error("Timing parameter out of range.");
    end

    localparam logic [19:0] MEAS_LAST = 20'(MEAS_CYCLES - 1);
    localparam logic [19:0] DC_UNIT   = 20'(DC_UNIT_CYCLES);

    // Two-flop synchronisers for the asynchronous levels.
    logic srcSync1_q;      // First stage, read only by the second.
    logic srcSync2_q;      // Synchronised supply source.
    logic srcPrev_q;       // Previous synchronised source, for edge detect.
    logic dcSync1_q;       // First stage, read only by the second.
    logic dcSync2_q;       // Synchronised low-input level.
    logic dcPrev_q;        // Previous low-input level.

    // Software-visible registers and the hidden delta reference.
    logic [7:0] adcStart_q;
    logic [7:0] adcStart_d;
    logic [7:0] batValue_q;
    logic [7:0] batValue_d;
    logic [7:0] enable_q;
    logic [7:0] enable_d;
    logic [7:0] delta_q;
    logic [7:0] delta_d;
    logic [7:0] peripheral_config_q;
    logic [7:0] peripheral_config_d;
    logic [7:0] switchCfg_q;
    logic [7:0] switchCfg_d;
    logic [7:0] batThresh_q;
    logic [7:0] batThresh_d;
    logic [7:0] ie2_q;
    logic [7:0] ie2_d;
    logic [7:0] lastVsw_q;   // Reference for the delta comparison.
    logic [7:0] lastVsw_d;

    // Measurement timer and low-input timeout state.
    logic [19:0] measCnt_q;
    logic [19:0] measCnt_d;
    logic [19:0] dcCnt_q;
    logic [19:0] dcCnt_d;
    logic        dcReq_q;
    logic        dcReq_d;
    logic        startPulse_q;
    logic        startPulse_d;

    // Combinational event terms.
    logic [NUM_EVENTS-1:0] eventSet;
    logic [NUM_EVENTS-1:0] flags;
    logic                  flagWrite;
    logic [8:0]            vswDiff;
    logic [7:0]            vswMag;
    logic [19:0]           dcLimit;
    logic                  anyEnabled;
    logic                  irq_q;
    logic                  irq_d;

    // Synchronisers run even while frozen would lose edges, so they obey the enable too.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            srcSync1_q <= 1'b1;
            srcSync2_q <= 1'b1;
            srcPrev_q  <= 1'b1;
            dcSync1_q  <= 1'b0;
            dcSync2_q  <= 1'b0;
            dcPrev_q   <= 1'b0;
        end
        else if (ce)
        begin
            srcSync1_q <= mainSupplyPin;
            srcSync2_q <= srcSync1_q;
            srcPrev_q  <= srcSync2_q;
            dcSync1_q  <= dcInputLowPin;
            dcSync2_q  <= dcSync1_q;
            dcPrev_q   <= dcSync2_q;
        end
    end

    // Magnitude of the switched-supply change since the last result.
    always_comb
    begin
        vswDiff = {1'b0, vswResult} - {1'b0, lastVsw_q};
        if (vswDiff[8])
        begin
            vswMag = 8'(-vswDiff);
        end
        else
        begin
            vswMag = vswDiff[7:0];
        end
    end

    // Event detection; flags set independently of the enables.
    always_comb
    begin
        eventSet = '0;
        eventSet[EV_SWITCH]  = srcPrev_q && !srcSync2_q;
        eventSet[EV_RESTORE] = !srcPrev_q && srcSync2_q;
        eventSet[EV_VSW]     = vswResultReady && ((vswMag > delta_q) || 1'b1);
        eventSet[EV_BATTERY] = batResultReady;
        eventSet[EV_DCIN]    = dcSync2_q && !dcPrev_q;
        eventSet[EV_SAG]     = sagDetected;
    end

    assign flagWrite = ce && sfrWr && (sfrAddr == ADDR_EVENT_FLAGS);

    // Sticky flags with write-zero-to-clear.
    event_flag_latch #(
        .WIDTH (NUM_EVENTS)
    ) u_flags (
        .sys_clk     (sys_clk),
        .arst_n      (arst_n),
        .ce          (ce),
        .setEvent    (eventSet),
        .writeStrobe (flagWrite),
        .writeData   (sfrWrData[NUM_EVENTS-1:0]),
        .flags       (flags)
    );

    // Register writes, result capture and the derived status bit.
    always_comb
    begin
        adcStart_d  = adcStart_q;
        batValue_d  = batValue_q;
        enable_d    = enable_q;
        delta_d     = delta_q;
        peripheral_config_d    = peripheral_config_q;
        switchCfg_d = switchCfg_q;
        batThresh_d = batThresh_q;
        ie2_d       = ie2_q;
        lastVsw_d   = lastVsw_q;
        if (sfrWr)
        begin
            if (sfrAddr == ADDR_ADC_START)
            begin
                adcStart_d = sfrWrData;
            end
            else if (sfrAddr == ADDR_EVENT_ENABLE)
            begin
                enable_d = sfrWrData;
            end
            else if (sfrAddr == ADDR_SUPPLY_DELTA)
            begin
                delta_d = sfrWrData;
            end
            else if (sfrAddr == ADDR_PERIPHERAL_CONFIG_CFG)
            begin
                peripheral_config_d = sfrWrData;
            end
            else if (sfrAddr == ADDR_SWITCH_CFG)
            begin
                switchCfg_d = sfrWrData;
            end
            else if (sfrAddr == ADDR_BAT_THRESH)
            begin
                batThresh_d = sfrWrData;
            end
            else if (sfrAddr == ADDR_IRQ_EN_PRIO2)
            begin
                ie2_d = sfrWrData;
            end
        end
        // The source bit is hardware owned; software writes to it are dropped.
        peripheral_config_d[SOURCE_BIT] = srcSync2_q;
        if (batResultReady)
        begin
            batValue_d = batResult;
        end
        if (vswResultReady)
        begin
            lastVsw_d = vswResult;
        end
    end

    // Background measurement timer; a software start also restarts the period.
    always_comb
    begin
        measCnt_d    = measCnt_q;
        startPulse_d = 1'b0;
        if (sfrWr && (sfrAddr == ADDR_ADC_START))
        begin
            startPulse_d = 1'b1;
            measCnt_d    = '0;
        end
        else if (measCnt_q == MEAS_LAST)
        begin
            startPulse_d = 1'b1;
            measCnt_d    = '0;
        end
        else
        begin
            measCnt_d = measCnt_q + 20'h00001;
        end
    end

    // Low-input switchover timeout: unit shifted by the two-bit select.
    always_comb
    begin
        dcLimit = DC_UNIT << switchCfg_q[1:0];
        dcCnt_d = dcCnt_q;
        dcReq_d = dcReq_q;
        if (!dcSync2_q || !switchCfg_q[DC_SWITCH_EN_BIT])
        begin
            dcCnt_d = '0;
            dcReq_d = 1'b0;
        end
        else if (dcCnt_q >= dcLimit - 20'h00001)
        begin
            dcReq_d = 1'b1;
        end
        else
        begin
            dcCnt_d = dcCnt_q + 20'h00001;
        end
    end

    // Shared interrupt: each flag gated by its enable, then the global enable.
    always_comb
    begin
        anyEnabled = |(flags & enable_q[NUM_EVENTS-1:0]);
        irq_d      = anyEnabled && ie2_q[GLOBAL_EN_BIT];
    end

    // All register state, frozen while the clock enable is low.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            adcStart_q   <= RST_ZERO;
            batValue_q   <= RST_ZERO;
            enable_q     <= RST_ZERO;
            delta_q      <= RST_SUPPLY_DELTA;
            peripheral_config_q     <= RST_PERIPHERAL_CONFIG;
            switchCfg_q  <= RST_ZERO;
            batThresh_q  <= RST_BAT_THRESH;
            ie2_q        <= RST_ZERO;
            lastVsw_q    <= RST_ZERO;
            measCnt_q    <= '0;
            dcCnt_q      <= '0;
            dcReq_q      <= 1'b0;
            startPulse_q <= 1'b0;
            irq_q        <= 1'b0;
        end
        else if (ce)
        begin
            adcStart_q   <= adcStart_d;
            batValue_q   <= batValue_d;
            enable_q     <= enable_d;
            delta_q      <= delta_d;
            peripheral_config_q     <= peripheral_config_d;
            switchCfg_q  <= switchCfg_d;
            batThresh_q  <= batThresh_d;
            ie2_q        <= ie2_d;
            lastVsw_q    <= lastVsw_d;
            measCnt_q    <= measCnt_d;
            dcCnt_q      <= dcCnt_d;
            dcReq_q      <= dcReq_d;
            startPulse_q <= startPulse_d;
            irq_q        <= irq_d;
        end
    end

    // Read decode; unmapped addresses read as zero.
    always_comb
    begin
        sfrRdData = 8'h00;
        if (sfrAddr == ADDR_ADC_START)
        begin
            sfrRdData = adcStart_q;
        end
        else if (sfrAddr == ADDR_BAT_ADC)
        begin
            sfrRdData = batValue_q;
        end
        else if (sfrAddr == ADDR_EVENT_ENABLE)
        begin
            sfrRdData = enable_q;
        end
        else if (sfrAddr == ADDR_SUPPLY_DELTA)
        begin
            sfrRdData = delta_q;
        end
        else if (sfrAddr == ADDR_PERIPHERAL_CONFIG_CFG)
        begin
            sfrRdData = peripheral_config_q;
        end
        else if (sfrAddr == ADDR_SWITCH_CFG)
        begin
            sfrRdData = switchCfg_q;
        end
        else if (sfrAddr == ADDR_EVENT_FLAGS)
        begin
            sfrRdData = {{(8 - NUM_EVENTS){1'b0}}, flags};
        end
        else if (sfrAddr == ADDR_BAT_THRESH)
        begin
            sfrRdData = batThresh_q;
        end
        else if (sfrAddr == ADDR_IRQ_EN_PRIO2)
        begin
            sfrRdData = ie2_q;
        end
    end

    assign adcStartPulse   = startPulse_q;
    assign dcSwitchoverReq = dcReq_q;
    assign supplyIrq       = irq_q;

    // Checks on the design's own outputs; they assume the clock enable is high.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    chk_switch_flag_set: assert property (ce && $past(ce) && eventSet[EV_SWITCH] |=> flags[EV_SWITCH])
        else $error("Switchover did not set its flag.");
    chk_restore_flag_set: assert property (ce && eventSet[EV_RESTORE] |=> flags[EV_RESTORE])
        else $error("Restore did not set its flag.");
    chk_flag_no_enable: assert property (ce && eventSet[EV_SWITCH] && !enable_q[EV_SWITCH] |=> flags[EV_SWITCH])
        else $error("Flag depended on its enable.");
    chk_flag_sticky: assert property (ce && flags[EV_SWITCH] && !flagWrite |=> flags[EV_SWITCH])
        else $error("Flag dropped without a write.");
    chk_flag_clear: assert property (flagWrite && !sfrWrData[EV_RESTORE] && !eventSet[EV_RESTORE] |=> !flags[EV_RESTORE])
        else $error("Write of zero did not clear the flag.");
    chk_source_bit: assert property (ce ##1 ce ##1 ce |-> peripheral_config_q[SOURCE_BIT] == $past(srcSync2_q))
        else $error("Source bit does not follow the supply.");
    chk_vsw_ready: assert property (ce && vswResultReady |=> flags[EV_VSW])
        else $error("Ready result did not set the flag.");
    chk_bat_ready: assert property (ce && batResultReady |=> flags[EV_BATTERY] && batValue_q == $past(batResult))
        else $error("Battery result not captured.");
    chk_sw_start: assert property (ce && sfrWr && sfrAddr == ADDR_ADC_START |=> adcStartPulse)
        else $error("Software start gave no conversion.");
    chk_irq_gate: assert property (ce |=> supplyIrq == ($past(anyEnabled) && $past(ie2_q[GLOBAL_EN_BIT])))
        else $error("Interrupt not gated correctly.");
    chk_irq_or: assert property (ce && ie2_q[GLOBAL_EN_BIT] && (flags[EV_SAG] && enable_q[EV_SAG]) |=> supplyIrq)
        else $error("Enabled flag gave no interrupt.");
    chk_dc_no_early: assert property (ce && $rose(dcSync2_q) |-> !dcSwitchoverReq)
        else $error("Switchover request came at once.");

    cov_switchover: cover property (eventSet[EV_SWITCH] ##[1:8] supplyIrq);
    cov_restore: cover property (eventSet[EV_RESTORE]);
    cov_dc_timeout: cover property (dcSwitchoverReq);
    cov_clear_race: cover property (flagWrite && |eventSet);
endmodule // power_supply_event_interrupts
`default_nettype wire

// ### rtl/psm_pkg.sv
// Constants shared by the supply-monitor event interrupt logic.
// Assumes an 8-bit special-function-register access port on the core clock.
`default_nettype none
package psm_pkg;
    // Register offsets on the special-function-register port.
    localparam logic [7:0] ADDR_ADC_START    = 8'hd8;
    localparam logic [7:0] ADDR_BAT_ADC      = 8'hdf;
    localparam logic [7:0] ADDR_EVENT_ENABLE = 8'hec;
    localparam logic [7:0] ADDR_SUPPLY_DELTA = 8'hf3;
    localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_CFG   = 8'hf4;
    localparam logic [7:0] ADDR_SWITCH_CFG   = 8'hf5;
    localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'hf8;
    localparam logic [7:0] ADDR_BAT_THRESH   = 8'hfa;
    localparam logic [7:0] ADDR_IRQ_EN_PRIO2 = 8'ha9;
    // Positions of the event bits, shared by the flag and enable registers.
    localparam int NUM_EVENTS   = 6;
    localparam int EV_VSW       = 0;
    localparam int EV_BATTERY   = 1;
    localparam int EV_DCIN      = 2;
    localparam int EV_RESTORE   = 3;
    localparam int EV_SWITCH    = 4;
    localparam int EV_SAG       = 5;
    // Other field positions.
    localparam int SOURCE_BIT   = 6;
    localparam int GLOBAL_EN_BIT = 0;
    localparam int DC_SWITCH_EN_BIT = 2;
    // Values after reset.
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_BAT_THRESH  = 8'h00;
    localparam logic [7:0] RST_SUPPLY_DELTA = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL_CONFIG      = 8'h40; // Source bit set: main supply assumed at reset.
    // Timing: clock rate, background measurement interval, low-input timeout unit.
    localparam int CLK_HZ           = 50_000_000;
    localparam int MEAS_INTERVAL_US = 1000;
    localparam int DC_TIMEOUT_US    = 1000;
    localparam int MEAS_INTERVAL_CYC = CLK_HZ / 1_000_000 * MEAS_INTERVAL_US;
    localparam int DC_TIMEOUT_CYC    = CLK_HZ / 1_000_000 * DC_TIMEOUT_US;
endpackage : psm_pkg
`default_nettype wire

// ### testbench/sfr_core_model.sv
// Core-side model of the special-function-register port: byte writes and reads.
// Assumes the block takes a write at the rising edge and answers reads combinationally.
`default_nettype none
module sfr_core_model (
    input  wire logic       sys_clk,   // Core clock.
    output logic      [7:0] sfrAddr,   // Register address.
    output logic            sfrWr,     // One-cycle write strobe.
    output logic      [7:0] sfrWrData, // Write data.
    input  wire logic [7:0] sfrRdData  // Read data from the block.
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle port values; the strobe must be low before reset is released.
    initial
    begin
        sfrAddr   = 8'h00;
        sfrWr     = 1'b0;
        sfrWrData = 8'h00;
    end
    // One write; idle cycles before it model a slow instruction stream.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input int idle);
        repeat (idle) @(posedge sys_clk);
        @(posedge sys_clk) #1;
        sfrAddr   = a;
        sfrWrData = d;
        sfrWr     = 1'b1;
        @(posedge sys_clk) #1;
        sfrWr     = 1'b0;
        // Released data shows the inverse, so a stale value never looks valid.
        sfrWrData = ~d;
    endtask
    // Software clears flags by writing zero to them and one elsewhere.
    task automatic clear_flags(input logic [7:0] mask);
        write_reg(8'hf8, ~mask, 0);
    endtask
    // Read: address set after an edge, data taken once it has settled.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk) #1;
        sfrAddr = a;
        #5;
        d = sfrRdData;
    endtask
endmodule // sfr_core_model
`default_nettype wire

// ### testbench/tb_power_supply_event_interrupts.sv
// Self-checking bench for the supply-monitor event interrupt block.
// Assumes the core model drives the register port; event inputs come from bench tasks.
`default_nettype none
module tb_power_supply_event_interrupts;
    timeunit 1ns;
    timeprecision 100ps;
    import psm_pkg::*;
    localparam int MEAS = 20; // Shortened measurement period.
    localparam int UNIT = 4;  // Shortened low-input timeout unit.
    // Register row: address, value after reset, value written, value read back.
    typedef struct packed { logic [7:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] e; } row_s;
    localparam row_s ROWS [10] = '{'{8'hd8, 8'h00, 8'h77, 8'h77}, '{8'hdf, 8'h00, 8'hff, 8'h00},
        '{8'hec, 8'h00, 8'h3f, 8'h3f}, '{8'hf3, 8'h00, 8'ha5, 8'ha5}, '{8'hf4, 8'h40, 8'h00, 8'h40},
        '{8'hf5, 8'h00, 8'h03, 8'h03}, '{8'hf8, 8'h00, 8'hff, 8'h00}, '{8'hfa, 8'h00, 8'h5a, 8'h5a},
        '{8'ha9, 8'h00, 8'hfe, 8'hfe}, '{8'h33, 8'h00, 8'hff, 8'h00}};
    localparam int EV_ORDER [6] = '{0, 1, 2, 4, 3, 5}; // Switchover comes before restore.
    logic       sys_clk;
    logic       ce;
    logic       arst_n;
    logic       mainSupplyPin, dcInputLowPin, sagDetected, vswResultReady, batResultReady;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData, vswResult, batResult, bitm;
    logic       sfrWr, adcStartPulse, dcSwitchoverReq, supplyIrq;
    int         num_errors = 0;
    int         n_checks   = 0;
    int         c;
    // Design under test with shortened timers.
    power_supply_event_interrupts #(.MEAS_CYCLES(MEAS), .DC_UNIT_CYCLES(UNIT)) i_power_supply_event_interrupts (
        .sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .mainSupplyPin(mainSupplyPin),
        .dcInputLowPin(dcInputLowPin), .sagDetected(sagDetected), .vswResultReady(vswResultReady),
        .vswResult(vswResult), .batResultReady(batResultReady), .batResult(batResult),
        .adcStartPulse(adcStartPulse), .dcSwitchoverReq(dcSwitchoverReq), .supplyIrq(supplyIrq));
    // Core model on the register port.
    sfr_core_model i_sfr_core_model (.sys_clk(sys_clk), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData));
    // Free-running 50 MHz clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Watchdog; the whole run needs a few hundred cycles.
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        results();
    end
    // Verdict and end of run.
    task automatic results();
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Compare of a byte result.
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Compare of a one-bit result.
    task automatic check1(input string what, input logic exp, input logic got);
        check8(what, {7'h00, exp}, {7'h00, got});
    endtask
    // Register read through the core model, then compare.
    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_sfr_core_model.read_reg(a, d);
        check8($sformatf("reg %h", a), exp, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_sfr_core_model.write_reg(a, d, 0);
    endtask
    // Raise one event; pin events need the synchroniser plus flag and interrupt stages.
    task automatic fire(input int k);
        @(posedge sys_clk) #1;
        case (k)
            0: vswResultReady = 1'b1;
            1: batResultReady = 1'b1;
            2: dcInputLowPin = 1'b1;
            3: mainSupplyPin = 1'b1;
            4: mainSupplyPin = 1'b0;
            default: sagDetected = 1'b1;
        endcase
        @(posedge sys_clk) #1;
        {vswResultReady, batResultReady, sagDetected} = 3'b000;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    // Counts cycles until the adc pulse (0) or the switchover request (1) is seen.
    task automatic count_to(input int which, input int limit, output int n);
        n = 0;
        while (n < limit && ((which != 0 ? dcSwitchoverReq : adcStartPulse) !== 1'b1))
        begin
            @(posedge sys_clk) #1;
            n++;
        end
    endtask
    // Main sequence.
    initial
    begin
        {arst_n, dcInputLowPin, sagDetected, vswResultReady, batResultReady} = 5'b00000;
        mainSupplyPin = 1'b1;
        ce = 1'b1;
        vswResult = 8'h3c;
        batResult = 8'h9c;
        repeat (16) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        // Reset values, write and read back, read-only, hardware-owned and unmapped places.
        foreach (ROWS[i])
        begin
            check_reg(ROWS[i].a, ROWS[i].r);
            i_sfr_core_model.write_reg(ROWS[i].a, ROWS[i].w, i % 2);
            check_reg(ROWS[i].a, ROWS[i].e);
        end
        // Each event: flag without enable, gating by event and global enables, write-zero clear.
        foreach (EV_ORDER[i])
        begin
            bitm = 8'h01 << EV_ORDER[i];
            wr(ADDR_EVENT_ENABLE, 8'h00);
            wr(ADDR_IRQ_EN_PRIO2, 8'h01);
            fire(EV_ORDER[i]);
            check_reg(ADDR_EVENT_FLAGS, bitm);
            check1("irq masked", 1'b0, supplyIrq);
            if (EV_ORDER[i] == 4)
                check_reg(ADDR_PERIPHERAL_CONFIG_CFG, 8'h00);
            if (EV_ORDER[i] == 3)
                check_reg(ADDR_PERIPHERAL_CONFIG_CFG, 8'h40);
            if (EV_ORDER[i] == 1)
                check_reg(ADDR_BAT_ADC, 8'h9c);
            @(posedge sys_clk) #1 dcInputLowPin = 1'b0;
            wr(ADDR_EVENT_ENABLE, bitm);
            repeat (2) @(posedge sys_clk);
            #1 check1("irq enabled", 1'b1, supplyIrq);
            wr(ADDR_IRQ_EN_PRIO2, 8'h00);
            repeat (2) @(posedge sys_clk);
            #1 check1("irq global off", 1'b0, supplyIrq);
            wr(ADDR_IRQ_EN_PRIO2, 8'h01);
            wr(ADDR_EVENT_FLAGS, 8'hff);
            check_reg(ADDR_EVENT_FLAGS, bitm);
            i_sfr_core_model.clear_flags(bitm);
            check_reg(ADDR_EVENT_FLAGS, 8'h00);
            #1 check1("irq cleared", 1'b0, supplyIrq);
        end
        // A clearing write in the same cycle as a new event leaves the flag set.
        fork
            wr(ADDR_EVENT_FLAGS, 8'h00);
            fire(5);
        join
        check_reg(ADDR_EVENT_FLAGS, 8'h20);
        // A low clock enable freezes all state: a sag pulse and a register write meanwhile are lost.
        wr(ADDR_EVENT_FLAGS, 8'h00);
        @(posedge sys_clk) #1 ce = 1'b0;
        fork
            wr(ADDR_SUPPLY_DELTA, 8'h11);
            fire(5);
        join
        ce = 1'b1;
        check_reg(ADDR_EVENT_FLAGS, 8'h00);
        check_reg(ADDR_SUPPLY_DELTA, 8'ha5);
        // Software start gives a pulse at once and restarts the background period.
        wr(ADDR_ADC_START, 8'h01);
        count_to(0, 3, c);
        check1("adc start", 1'b1, c <= 1);
        @(posedge sys_clk) #1;
        count_to(0, 3 * MEAS, c);
        check1("adc period", 1'b1, c >= MEAS - 2 && c <= MEAS);
        // Low DC input to switchover request, for every timeout selection.
        for (int s = 0; s < 4; s++)
        begin
            wr(ADDR_SWITCH_CFG, 8'h04 | 8'(s));
            dcInputLowPin = 1'b1;
            count_to(1, 200, c);
            check1("dc timeout", 1'b1, c >= (UNIT << s) - 1 && c <= (UNIT << s) + 5);
            dcInputLowPin = 1'b0;
            repeat (4) @(posedge sys_clk);
            #1 check1("dc release", 1'b0, dcSwitchoverReq);
        end
        // Reset in mid-run clears flags, the global enable and the interrupt.
        wr(ADDR_EVENT_ENABLE, 8'h3f);
        repeat (2) @(posedge sys_clk);
        #1 check1("irq before reset", 1'b1, supplyIrq);
        arst_n = 1'b0;
        #1 check1("irq in reset", 1'b0, supplyIrq);
        @(posedge sys_clk) #1 arst_n = 1'b1;
        check_reg(ADDR_EVENT_FLAGS, 8'h00);
        check_reg(ADDR_IRQ_EN_PRIO2, 8'h00);
        results();
    end
endmodule // tb_power_supply_event_interrupts
`default_nettype wire
